// [pkg/serdes_lane_sync_regs.vh]
// Register indices, field positions, reset values and timing counts for lane sync
`ifndef SERDES_LANE_SYNC_REGS_VH
`define SERDES_LANE_SYNC_REGS_VH

// Register indices; byte address is four times the index
`define IDX_GLOBAL_A 18'h30005
`define IDX_GLOBAL_B 18'h30105
`define IDX_BSYNC_A 18'h30800
`define IDX_BSYNC_B 18'h30900
`define IDX_LOOP_A 18'h30801
`define IDX_LOOP_B 18'h30901
`define IDX_ALIGN_EN_A 18'h30810
`define IDX_ALIGN_EN_B 18'h30910
`define IDX_MODE_A 18'h30811
`define IDX_MODE_B 18'h30911
`define IDX_LANE0_BASE 18'h30020
`define IDX_LANE1_BASE 18'h30030
`define IDX_LANE2_BASE 18'h30120
`define IDX_LANE3_BASE 18'h30130
`define OFS_STATUS 18'h00000
`define OFS_TXCFG 18'h00002
`define OFS_RXCFG 18'h00003

// Field positions
`define BIT_SOFT_RESET 2
`define BIT_HALF_RATE 0
`define BIT_CODEC_EN 1
`define BIT_FC_LINK 2
`define ST_PLL_LOCK 0
`define ST_SYNC_LOST 1
`define ST_COMMA_TO 2
`define ST_SYNCED 3
`define BSYNC_LOCK_BASE 4
`define ALIGN_EN_STROBE_BASE 0
`define FIRST_LANE_CHANNEL 2

// Reset values
`define GLOBAL_RST 8'h22
`define CTRL_RST 8'h00
`define STICKY_RST 1'b1

// Alignment mode codes and their decoded form
`define MODE_NONE 8'h00
`define MODE_TWIN 8'h0a
`define MODE_QUAD 8'h0f
`define ALN_NONE 2'h0
`define ALN_TWIN 2'h1
`define ALN_QUAD 2'h2

// Comma pattern with bit a in the lowest position
`define COMMA_POS 7'h7c
`define COMMA_NEG 7'h03

// Timing
`define CLK_FREQ_HZ 10000000
`define READY_TIME_US 3000
`define READY_CYC (`READY_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define COMMA_TIMER_CYC 2048

// Lane sync acquisition and hysteresis
`define ACQ_COMMAS 3'h4
`define SYNC_ERR_MAX 2'h3
`define GOOD_RUN 2'h3

`endif

// [src/lane_sync_fsm.v]
// Per-lane code-group checker, comma timer and synchronisation state machine
`timescale 1ns/1ns
`include "serdes_lane_sync_regs.vh"

module lane_sync_fsm #(
    parameter TIMER_CYC = `COMMA_TIMER_CYC,
    parameter TIMER_W = 12
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [9:0] group_i,
    input wire valid_i,
    output reg [9:0] group_o,
    output reg valid_o,
    output reg special_o,
    output reg comma_o,
    output reg good_o,
    output reg bad_o,
    output reg synced_o,
    output reg timeout_o,
    output reg lost_o
);

localparam ST_UNSYNC = 2'h0;
localparam ST_ACQ = 2'h1;
localparam ST_CONFIRM = 2'h2;
localparam ST_SYNC = 2'h3;
localparam integer TIMER_END = TIMER_CYC - 1;
localparam [TIMER_W-1:0] TIMER_LAST = TIMER_END[TIMER_W-1:0];

// Bit a moved to the top so the code table reads as printed
wire [9:0] g = {group_i[0], group_i[1], group_i[2], group_i[3], group_i[4],
                group_i[5], group_i[6], group_i[7], group_i[8], group_i[9]};

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [2:0] acq_cnt_ff;
reg [2:0] nxt_acq_cnt;
reg [1:0] err_cnt_ff;
reg [1:0] nxt_err_cnt;
reg [1:0] good_cnt_ff;
reg [1:0] nxt_good_cnt;
reg rd_ff;
reg nxt_rd;
reg [TIMER_W-1:0] timer_ff;
reg [2:0] ones6;
reg [2:0] ones4;
reg rd_mid;
reg rd_err;
reg is_special;
reg lost;
integer i;

////////////////////////////////////////////////////////////////////////////////
// twelve special characters
always @* begin
    case (g)
        10'h0f4, 10'h30b, 10'h0f9, 10'h306, 10'h0f5, 10'h30a,
        10'h0f3, 10'h30c, 10'h0f2, 10'h30d, 10'h0fa, 10'h305,
        10'h0f6, 10'h309, 10'h0f8, 10'h307, 10'h3a8, 10'h057,
        10'h368, 10'h097, 10'h2e8, 10'h117, 10'h1e8, 10'h217: is_special = 1'b1;
        default: is_special = 1'b0;
    endcase
end

always @* begin
    ones6 = 3'h0;
    ones4 = 3'h0;
    for (i = 4; i < 10; i = i + 1) begin
        ones6 = ones6 + {2'h0, g[i]};
    end
    for (i = 0; i < 4; i = i + 1) begin
        ones4 = ones4 + {2'h0, g[i]};
    end
    rd_err = 1'b0;
    rd_mid = rd_ff;
    if (ones6 == 3'h4) begin
        rd_err = rd_ff;
        rd_mid = 1'b1;
    end else if (ones6 == 3'h2) begin
        rd_err = ~rd_ff;
        rd_mid = 1'b0;
    end
    nxt_rd = rd_mid;
    if (ones4 == 3'h3) begin
        rd_err = rd_err | rd_mid;
        nxt_rd = 1'b1;
    end else if (ones4 == 3'h1) begin
        rd_err = rd_err | ~rd_mid;
        nxt_rd = 1'b0;
    end
end

wire weight_ok = (ones6 >= 3'h2) && (ones6 <= 3'h4) && (ones4 >= 3'h1) && (ones4 <= 3'h3);
wire good = weight_ok & ~rd_err;
// comma only in a good group
wire comma = good & is_special & ((group_i[6:0] == `COMMA_POS) | (group_i[6:0] == `COMMA_NEG));

////////////////////////////////////////////////////////////////////////////////
// acquisition count; error hysteresis
always @* begin
    nxt_state = state_ff;
    nxt_acq_cnt = acq_cnt_ff;
    nxt_err_cnt = err_cnt_ff;
    nxt_good_cnt = good_cnt_ff;
    lost = 1'b0;
    case (state_ff)
        ST_UNSYNC: begin
            if (comma) begin
                nxt_state = ST_ACQ;
                nxt_acq_cnt = 3'h1;
            end
        end
        ST_ACQ: begin
            if (!good) begin
                nxt_state = ST_UNSYNC;
            end else if (comma) begin
                nxt_acq_cnt = acq_cnt_ff + 3'h1;
                if (acq_cnt_ff == `ACQ_COMMAS - 3'h1) begin
                    nxt_state = ST_CONFIRM;
                end
            end
        end
        ST_CONFIRM: begin
            nxt_err_cnt = 2'h0;
            nxt_good_cnt = 2'h0;
            nxt_state = good ? ST_SYNC : ST_UNSYNC;
        end
        ST_SYNC: begin
            if (!good) begin
                nxt_good_cnt = 2'h0;
                if (err_cnt_ff == `SYNC_ERR_MAX) begin
                    nxt_state = ST_UNSYNC;
                    lost = 1'b1;
                end else begin
                    nxt_err_cnt = err_cnt_ff + 2'h1;
                end
            end else if (err_cnt_ff != 2'h0) begin
                if (good_cnt_ff == `GOOD_RUN) begin
                    nxt_err_cnt = err_cnt_ff - 2'h1;
                    nxt_good_cnt = 2'h0;
                end else begin
                    nxt_good_cnt = good_cnt_ff + 2'h1;
                end
            end
        end
        default: nxt_state = ST_UNSYNC;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i) begin
    if (rst_i) begin
        state_ff <= ST_UNSYNC;
        acq_cnt_ff <= 3'h0;
        err_cnt_ff <= 2'h0;
        good_cnt_ff <= 2'h0;
        rd_ff <= 1'b0;
        timer_ff <= {TIMER_W{1'b0}};
        group_o <= 10'h000;
        valid_o <= 1'b0;
        special_o <= 1'b0;
        comma_o <= 1'b0;
        good_o <= 1'b0;
        bad_o <= 1'b0;
        synced_o <= 1'b0;
        timeout_o <= 1'b0;
        lost_o <= 1'b0;
    end else if (ce_i) begin
        valid_o <= valid_i;
        timeout_o <= 1'b0;
        lost_o <= 1'b0;
        // Special flag only stands beside a valid group
        special_o <= 1'b0;
        comma_o <= 1'b0;
        good_o <= 1'b0;
        bad_o <= 1'b0;
        if (valid_i) begin
            state_ff <= nxt_state;
            acq_cnt_ff <= nxt_acq_cnt;
            err_cnt_ff <= nxt_err_cnt;
            good_cnt_ff <= nxt_good_cnt;
            rd_ff <= nxt_rd;
            group_o <= group_i;
            special_o <= is_special;
            comma_o <= comma;
            good_o <= good;
            // Wrong disparity counts as bad as well as an invalid group
            bad_o <= ~good;
            synced_o <= (nxt_state == ST_SYNC);
            lost_o <= lost;
            if (comma) begin
                timer_ff <= {TIMER_W{1'b0}};
            end else if (timer_ff == TIMER_LAST) begin
                timer_ff <= {TIMER_W{1'b0}};
                timeout_o <= 1'b1;
            end else begin
                timer_ff <= timer_ff + {{(TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

endmodule

// [src/serdes_lane_sync.v]
// Four-lane receive alignment, lane synchronisation and configuration registers
`timescale 1ns/1ns
`include "serdes_lane_sync_regs.vh"

module serdes_lane_sync #(
    parameter READY_CYCLES = `READY_CYC,
    parameter RDY_W = 16,
    parameter COMMA_TIMER_CYC = `COMMA_TIMER_CYC,
    parameter TIMER_W = 12
) (
    input wire CLK_I,
    input wire RST_I,
    input wire CE_I,
    input wire [19:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output reg [31:0] AVS_READDATA_O,
    output reg AVS_WAITREQUEST_O,
    input wire [39:0] RX_DATA_I,
    input wire [3:0] RX_VALID_I,
    input wire [3:0] PLL_LOCK_I,
    output wire [39:0] ALIGNED_DATA_O,
    output wire [3:0] ALIGNED_VALID_O,
    output wire [3:0] ALIGNED_K_O,
    output wire [3:0] LANE_SYNCED_O,
    output wire [3:0] RX_LOCK_TO_DATA_O,
    output wire [3:0] SERIAL_LOOPBACK_O,
    output wire [3:0] TX_HALF_RATE_O,
    output wire [3:0] TX_ENCODE_O,
    output wire [3:0] RX_HALF_RATE_O,
    output wire [3:0] FC_LINK_EN_O,
    output reg [3:0] ALIGN_MODE_O,
    output reg [1:0] ALIGN_FIFO_EN_O,
    output reg DEVICE_READY_O
);

localparam NL = 4;
localparam integer RDY_END = READY_CYCLES - 1;
localparam [RDY_W-1:0] RDY_LAST = RDY_END[RDY_W-1:0];

function [17:0] lane_base;
    input integer l;
    begin
        case (l)
            0: lane_base = `IDX_LANE0_BASE;
            1: lane_base = `IDX_LANE1_BASE;
            2: lane_base = `IDX_LANE2_BASE;
            default: lane_base = `IDX_LANE3_BASE;
        endcase
    end
endfunction

reg [7:0] global_ff [0:1];
reg [7:0] bsync_ff [0:1];
reg [7:0] loop_ff [0:1];
reg [7:0] algen_ff [0:1];
reg [7:0] mode_ff [0:1];
reg [7:0] txcfg_ff [0:NL-1];
reg [7:0] rxcfg_ff [0:NL-1];
reg [RDY_W-1:0] rdy_cnt_ff;
reg [7:0] rd_val;
reg [NL-1:0] rc_stb;
reg [1:0] nxt_mode0;
reg [1:0] nxt_mode1;
wire [8*NL-1:0] lane_stat;
integer k;
integer j;

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, then a single accept cycle
wire [17:0] idx = AVS_ADDRESS_I[19:2];
wire word_ok = (AVS_ADDRESS_I[1:0] == 2'h0);
wire req = AVS_READ_I | AVS_WRITE_I;
wire accept = req & ~AVS_WAITREQUEST_O;
wire wr_en = accept & AVS_WRITE_I & word_ok & AVS_BYTEENABLE_I[0];
wire rd_acc = accept & AVS_READ_I & word_ok;

always @(posedge CLK_I) begin
    if (RST_I) begin
        AVS_WAITREQUEST_O <= 1'b1;
        AVS_READDATA_O <= 32'h00000000;
    end else if (CE_I) begin
        AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
        // Data captured a cycle early so it stands on the accept edge
        if (AVS_READ_I & AVS_WAITREQUEST_O) begin
            AVS_READDATA_O <= {24'h000000, rd_val};
        end
    end
end

always @* begin
    rd_val = 8'h00;
    rc_stb = {NL{1'b0}};
    if (word_ok) begin
        case (idx)
            `IDX_GLOBAL_A: rd_val = global_ff[0];
            `IDX_GLOBAL_B: rd_val = global_ff[1];
            `IDX_BSYNC_A: rd_val = bsync_ff[0];
            `IDX_BSYNC_B: rd_val = bsync_ff[1];
            `IDX_LOOP_A: rd_val = loop_ff[0];
            `IDX_LOOP_B: rd_val = loop_ff[1];
            `IDX_ALIGN_EN_A: rd_val = algen_ff[0];
            `IDX_ALIGN_EN_B: rd_val = algen_ff[1];
            `IDX_MODE_A: rd_val = mode_ff[0];
            `IDX_MODE_B: rd_val = mode_ff[1];
            default: rd_val = 8'h00;
        endcase
        for (j = 0; j < NL; j = j + 1) begin
            if (idx == lane_base(j) + `OFS_STATUS) begin
                rd_val = lane_stat[8*j +: 8];
                // sticky lost and timeout bits cleared by the accepted read
                rc_stb[j] = rd_acc;
            end
            if (idx == lane_base(j) + `OFS_TXCFG) begin
                rd_val = txcfg_ff[j];
            end
            if (idx == lane_base(j) + `OFS_RXCFG) begin
                rd_val = rxcfg_ff[j];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers; unmapped writes are dropped
always @(posedge CLK_I) begin
    if (RST_I) begin
        for (k = 0; k < 2; k = k + 1) begin
            global_ff[k] <= `GLOBAL_RST;
            bsync_ff[k] <= `CTRL_RST;
            loop_ff[k] <= `CTRL_RST;
            algen_ff[k] <= `CTRL_RST;
            mode_ff[k] <= `MODE_NONE;
        end
        for (k = 0; k < NL; k = k + 1) begin
            txcfg_ff[k] <= `CTRL_RST;
            rxcfg_ff[k] <= `CTRL_RST;
        end
    end else if (CE_I && wr_en) begin
        case (idx)
            `IDX_GLOBAL_A: global_ff[0] <= AVS_WRITEDATA_I[7:0];
            `IDX_GLOBAL_B: global_ff[1] <= AVS_WRITEDATA_I[7:0];
            // byte aligner enabled from here; loop_ff and algen_ff writes also steer it
            `IDX_BSYNC_A: bsync_ff[0] <= AVS_WRITEDATA_I[7:0];
            `IDX_BSYNC_B: bsync_ff[1] <= AVS_WRITEDATA_I[7:0];
            `IDX_LOOP_A: loop_ff[0] <= AVS_WRITEDATA_I[7:0];
            `IDX_LOOP_B: loop_ff[1] <= AVS_WRITEDATA_I[7:0];
            `IDX_ALIGN_EN_A: algen_ff[0] <= AVS_WRITEDATA_I[7:0];
            `IDX_ALIGN_EN_B: algen_ff[1] <= AVS_WRITEDATA_I[7:0];
            `IDX_MODE_A: mode_ff[0] <= AVS_WRITEDATA_I[7:0];
            `IDX_MODE_B: mode_ff[1] <= AVS_WRITEDATA_I[7:0];
            default: ;
        endcase
        for (k = 0; k < NL; k = k + 1) begin
            if (idx == lane_base(k) + `OFS_TXCFG) begin
                txcfg_ff[k] <= AVS_WRITEDATA_I[7:0];
            end
            if (idx == lane_base(k) + `OFS_RXCFG) begin
                rxcfg_ff[k] <= AVS_WRITEDATA_I[7:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Alignment mode decode; unknown codes fall back to bypass
always @* begin
    case (mode_ff[0])
        `MODE_TWIN: nxt_mode0 = `ALN_TWIN;
        `MODE_QUAD: nxt_mode0 = `ALN_QUAD;
        default: nxt_mode0 = `ALN_NONE;
    endcase
    case (mode_ff[1])
        `MODE_TWIN: nxt_mode1 = `ALN_TWIN;
        `MODE_QUAD: nxt_mode1 = `ALN_QUAD;
        default: nxt_mode1 = `ALN_NONE;
    endcase
end

always @(posedge CLK_I) begin
    if (RST_I) begin
        ALIGN_MODE_O <= {`ALN_NONE, `ALN_NONE};
        ALIGN_FIFO_EN_O <= 2'h0;
        rdy_cnt_ff <= {RDY_W{1'b0}};
        DEVICE_READY_O <= 1'b0;
    end else if (CE_I) begin
        ALIGN_MODE_O <= {nxt_mode1, nxt_mode0};
        ALIGN_FIFO_EN_O <= {nxt_mode1 != `ALN_NONE, nxt_mode0 != `ALN_NONE};
        if (!DEVICE_READY_O) begin
            if (rdy_cnt_ff == RDY_LAST) begin
                DEVICE_READY_O <= 1'b1;
            end else begin
                rdy_cnt_ff <= rdy_cnt_ff + {{(RDY_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-lane aligner, sync machine and status
genvar l;
genvar o;
generate
    for (l = 0; l < NL; l = l + 1) begin : g_lane
        localparam B = l / 2;
        localparam CH = `FIRST_LANE_CHANNEL + (l % 2);

        reg lock_meta_ff;
        reg lock_sync_ff;
        reg pll_flag_ff;
        reg [9:0] prev_ff;
        reg [3:0] offset_ff;
        reg [9:0] group_ff;
        reg gvalid_ff;
        reg strobe_d_ff;
        reg realign_pend_ff;
        reg lost_sticky_ff;
        reg to_sticky_ff;
        wire [9:0] hit;
        reg [3:0] hit_ofs;
        reg hit_any;
        integer h;
        wire [9:0] cur = RX_DATA_I[10*l +: 10];
        // bit a earliest: window[0] arrived first
        wire [19:0] window = {cur, prev_ff};
        wire [19:0] shifted = window >> offset_ff;
        wire byte_sync = bsync_ff[B][CH];
        wire lock_to_data = bsync_ff[B][`BSYNC_LOCK_BASE + CH];
        wire no_align = loop_ff[B][`BSYNC_LOCK_BASE + CH];
        wire strobe = algen_ff[B][`ALIGN_EN_STROBE_BASE + CH];
        wire lane_rst = RST_I | global_ff[B][`BIT_SOFT_RESET] | ~rxcfg_ff[l][`BIT_CODEC_EN];
        wire timeout;
        wire lost;
        wire synced;

        // comma search at every bit offset
        for (o = 0; o < 10; o = o + 1) begin : g_ofs
            assign hit[o] = (window[o +: 7] == `COMMA_POS) | (window[o +: 7] == `COMMA_NEG);
        end

        always @* begin
            hit_any = |hit;
            hit_ofs = 4'h0;
            for (h = 9; h >= 0; h = h - 1) begin
                if (hit[h]) begin
                    hit_ofs = h[3:0];
                end
            end
        end

        always @(posedge CLK_I) begin
            if (lane_rst) begin
                prev_ff <= 10'h000;
                offset_ff <= 4'h0;
                group_ff <= 10'h000;
                gvalid_ff <= 1'b0;
                realign_pend_ff <= 1'b0;
                strobe_d_ff <= 1'b0;
            end else if (CE_I) begin
                strobe_d_ff <= strobe;
                gvalid_ff <= RX_VALID_I[l];
                if (RX_VALID_I[l]) begin
                    prev_ff <= cur;
                    group_ff <= shifted[9:0];
                end
                // realign when enabled or after strobe edge
                if (RX_VALID_I[l] && hit_any && !no_align && (byte_sync || realign_pend_ff)) begin
                    offset_ff <= hit_ofs;
                    realign_pend_ff <= 1'b0;
                end else if (strobe && !strobe_d_ff) begin
                    realign_pend_ff <= 1'b1;
                end
            end
        end

        always @(posedge CLK_I) begin
            if (RST_I) begin
                lock_meta_ff <= 1'b0;
                lock_sync_ff <= 1'b0;
                pll_flag_ff <= 1'b0;
                lost_sticky_ff <= `STICKY_RST;
                to_sticky_ff <= `STICKY_RST;
            end else if (CE_I) begin
                lock_meta_ff <= PLL_LOCK_I[l];
                lock_sync_ff <= lock_meta_ff;
                // no lock reported while on reference
                pll_flag_ff <= lock_sync_ff & lock_to_data;
                // a new event outranks the read clear
                if (lost) begin
                    lost_sticky_ff <= 1'b1;
                end else if (rc_stb[l]) begin
                    lost_sticky_ff <= 1'b0;
                end
                if (timeout) begin
                    to_sticky_ff <= 1'b1;
                end else if (rc_stb[l]) begin
                    to_sticky_ff <= 1'b0;
                end
            end
        end

        assign lane_stat[8*l +: 8] = {4'h0, synced, to_sticky_ff, lost_sticky_ff, pll_flag_ff};

        lane_sync_fsm #(
            .TIMER_CYC(COMMA_TIMER_CYC),
            .TIMER_W(TIMER_W)
        ) u_fsm (
            .clk_i(CLK_I),
            .rst_i(lane_rst),
            .ce_i(CE_I),
            .group_i(group_ff),
            .valid_i(gvalid_ff),
            .group_o(ALIGNED_DATA_O[10*l +: 10]),
            .valid_o(ALIGNED_VALID_O[l]),
            .special_o(ALIGNED_K_O[l]),
            .comma_o(),
            .good_o(),
            .bad_o(),
            .synced_o(synced),
            .timeout_o(timeout),
            .lost_o(lost)
        );

        assign LANE_SYNCED_O[l] = synced;
        assign RX_LOCK_TO_DATA_O[l] = bsync_ff[B][`BSYNC_LOCK_BASE + CH];
        assign SERIAL_LOOPBACK_O[l] = loop_ff[B][CH];
        assign TX_HALF_RATE_O[l] = txcfg_ff[l][`BIT_HALF_RATE];
        assign TX_ENCODE_O[l] = txcfg_ff[l][`BIT_CODEC_EN];
        assign RX_HALF_RATE_O[l] = rxcfg_ff[l][`BIT_HALF_RATE];
        assign FC_LINK_EN_O[l] = rxcfg_ff[l][`BIT_FC_LINK];
    end
endgenerate

endmodule

// [testbench/serdes_lane_sync_properties.sv]
// Checker for bus answer, ready delay and lane outputs
`timescale 1ns/1ns
module lane_sync_checker (
    input wire CLK_I,
    input wire RST_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire AVS_WAITREQUEST_O,
    input wire [31:0] AVS_READDATA_O,
    input wire [3:0] RX_VALID_I,
    input wire [3:0] ALIGNED_VALID_O,
    input wire [3:0] ALIGNED_K_O,
    input wire [3:0] LANE_SYNCED_O,
    input wire [3:0] ALIGN_MODE_O,
    input wire DEVICE_READY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////
    bus_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("bus request not answered");
    read_upper_a: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    ready_hold_a: assert property (DEVICE_READY_O |=> DEVICE_READY_O)
        else $error("ready dropped");
    ready_delay_a: assert property ($fell(RST_I) |-> !DEVICE_READY_O [*8])
        else $error("ready too early");
    sync_cause_a: assert property ($rose(LANE_SYNCED_O[0]) |-> ALIGNED_VALID_O[0])
        else $error("sync without group");
    k_valid_a: assert property (ALIGNED_K_O[0] |-> ALIGNED_VALID_O[0])
        else $error("special flag without group");
    group_latency_a: assert property (ALIGNED_VALID_O[0] |-> $past(RX_VALID_I[0], 2))
        else $error("group out without group in");
    mode_code_a: assert property (ALIGN_MODE_O[1:0] != 2'h3 && ALIGN_MODE_O[3:2] != 2'h3)
        else $error("illegal alignment mode");
    sync_up_c: cover property ($rose(LANE_SYNCED_O[0]));
    sync_drop_c: cover property ($fell(LANE_SYNCED_O[0]));
    ready_c: cover property ($rose(DEVICE_READY_O));
endmodule
bind serdes_lane_sync lane_sync_checker i_chk (.CLK_I, .RST_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O,
    .AVS_READDATA_O, .RX_VALID_I, .ALIGNED_VALID_O, .ALIGNED_K_O, .LANE_SYNCED_O, .ALIGN_MODE_O, .DEVICE_READY_O);

// [testbench/remote_lane_model.sv]
// Far-end lane model sending idle sets, commas or broken groups
`timescale 1ns/1ns
module remote_lane_model (
    input wire clk_i,
    input wire [1:0] mode_i,
    input wire [7:0] count_i,
    input wire start_i,
    output reg [9:0] data_o,
    output reg valid_o
);
    reg [7:0] left_ff = 8'h00;
    reg [1:0] pos_ff = 2'h0;
    reg rd_ff = 1'b0;
    initial begin
        data_o = 10'h000;
        valid_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        valid_o <= (left_ff != 8'h00) && !start_i;
        if (start_i) begin
            left_ff <= count_i;
        end else if (left_ff == 8'h00) begin
            // Released line toggles so no stale value survives
            data_o <= ~data_o;
        end else begin
            left_ff <= left_ff - 8'h01;
            pos_ff <= pos_ff + 2'h1;
            if (mode_i == 2'h3) begin
                data_o <= 10'h000;
            // Comma by disparity, bit a lowest
            end else if (mode_i == 2'h2 || pos_ff == 2'h0) begin
                data_o <= rd_ff ? 10'h283 : 10'h17c;
                rd_ff <= ~rd_ff;
            end else begin
                data_o <= (pos_ff == 2'h1) ? 10'h115 : 10'h155;
                rd_ff <= 1'b0;
            end
        end
    end
endmodule

// [testbench/serdes_lane_sync_tb_top.sv]
// Bench for lane sync: registers, reset, acquisition and loss
`timescale 1ns/1ns
module serdes_lane_sync_tb_top;
    reg CLK_I = 1'b0;
    reg RST_I = 1'b1;
    reg [19:0] adr = 20'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [1:0] md = 2'h0;
    reg [7:0] cnt = 8'h0;
    reg go = 1'b0;
    reg [31:0] q;
    reg [37:0] row [0:7];
    wire [1:0] fen;
    wire [39:0] adat;
    wire [31:0] rdat;
    wire wreq;
    wire ready;
    wire lval;
    wire [9:0] ldat;
    wire [3:0] sync;
    wire [3:0] amode;
    integer bad_count = 0;
    integer tests_run = 0;
    integer i;
    serdes_lane_sync #(.READY_CYCLES(20), .COMMA_TIMER_CYC(32)) i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(1'b1),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .RX_DATA_I({30'h0, ldat}), .RX_VALID_I({3'h0, lval}),
        .PLL_LOCK_I(4'hf), .ALIGNED_DATA_O(adat), .ALIGNED_VALID_O(), .ALIGNED_K_O(), .LANE_SYNCED_O(sync),
        .RX_LOCK_TO_DATA_O(), .SERIAL_LOOPBACK_O(), .TX_HALF_RATE_O(), .TX_ENCODE_O(), .RX_HALF_RATE_O(),
        .FC_LINK_EN_O(), .ALIGN_MODE_O(amode), .ALIGN_FIFO_EN_O(fen), .DEVICE_READY_O(ready));
    remote_lane_model i_far (.clk_i(CLK_I), .mode_i(md), .count_i(cnt), .start_i(go), .data_o(ldat), .valid_o(lval));
    initial forever #50 CLK_I = ~CLK_I;
    ////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task check(input [63:0] nm, input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task bus(input w, input [19:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge CLK_I);
            adr <= a;
            wd <= {24'h0, d};
            rd <= !w;
            wr <= w;
            n = 0;
            do begin
                @(posedge CLK_I);
                n = n + 1;
            end while (wreq !== 1'b0 && n < 20);
            if (wreq !== 1'b0) begin
                bad_count = bad_count + 1;
                stop_test;
            end
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task send(input [1:0] m, input [7:0] n);
        begin
            @(posedge CLK_I);
            md <= m;
            cnt <= n;
            go <= 1'b1;
            @(posedge CLK_I);
            go <= 1'b0;
            repeat (n + 4) @(posedge CLK_I);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        row[0] = {20'hc2044, 8'h0a, 8'h0a, 2'h1};
        row[1] = {20'hc2044, 8'h0f, 8'h0f, 2'h2};
        row[2] = {20'hc2044, 8'h55, 8'h55, 2'h0};
        row[3] = {20'h00004, 8'h5a, 8'h00, 2'h0};
        row[4] = {20'hc2000, 8'h44, 8'h44, 2'h0};
        // lane left at full rate, decoding on
        row[5] = {20'hc008c, 8'h02, 8'h02, 2'h0};
        // legacy power-down bit, not stored here
        row[6] = {20'hc0008, 8'h02, 8'h00, 2'h0};
        // legacy kept out of alignment groups
        row[7] = {20'hc2040, 8'h00, 8'h00, 2'h0};
        repeat (5) @(posedge CLK_I);
        RST_I <= 1'b0;
        repeat (10) @(posedge CLK_I);
        check("ready", ready, 1'b0);
        repeat (12) @(posedge CLK_I);
        check("ready", ready, 1'b1);
        bus(1'b0, 20'hc0014, 8'h0);
        check("global", q, 32'h22);
        bus(1'b0, 20'hc0080, 8'h0);
        check("stale", q, 32'h06);
        bus(1'b0, 20'hc0080, 8'h0);
        check("status", q, 32'h00);
        for (i = 0; i < 8; i = i + 1) begin
            bus(1'b1, row[i][37:18], row[i][17:10]);
            bus(1'b0, row[i][37:18], 8'h0);
            check("reg", q, row[i][9:2]);
            check("mode", amode[1:0], row[i][1:0]);
            check("fifo", fen[0], row[i][1:0] != 2'h0);
        end
        // Aligner holds one word back until the next arrives
        send(2'h1, 8'd14);
        check("sync", sync[0], 1'b0);
        send(2'h1, 8'd1);
        check("sync", sync[0], 1'b1);
        check("data", adat[9:0], 10'h115);
        bus(1'b0, 20'hc0080, 8'h0);
        check("status", q, 32'h09);
        bus(1'b1, 20'hc0014, 8'h26);
        bus(1'b1, 20'hc0014, 8'h22);
        check("sync", sync[0], 1'b0);
        send(2'h2, 8'd5);
        check("sync", sync[0], 1'b0);
        send(2'h2, 8'd1);
        check("sync", sync[0], 1'b1);
        send(2'h3, 8'd4);
        check("sync", sync[0], 1'b1);
        send(2'h3, 8'd1);
        check("sync", sync[0], 1'b0);
        bus(1'b0, 20'hc0080, 8'h0);
        check("lost", q, 32'h03);
        // 32 groups without a comma expire the timer once
        send(2'h3, 8'd40);
        bus(1'b0, 20'hc0080, 8'h0);
        check("timeout", q, 32'h05);
        stop_test;
    end
endmodule
